//--- design/sbch_map.svh
// Byte codes, lengths and address constants of the serial boot command handler
`ifndef SBCH_MAP_SVH
`define SBCH_MAP_SVH

`define SBCH_MATCH_BYTE  8'h5A
`define SBCH_ERR_HDR1    8'hA1
`define SBCH_ERR_HDR2    8'hA3
`define SBCH_ERR_BAUD    8'h62
`define SBCH_ERR_CMD     8'h63

`define SBCH_CMD_ERASE   8'hF0
`define SBCH_CMD_WRITE   8'h30
`define SBCH_CMD_LOAD    8'h60
`define SBCH_CMD_SUM     8'h90
`define SBCH_CMD_ID      8'hC0
`define SBCH_CMD_STAT    8'hC3
`define SBCH_CMD_SECURE  8'hFA

`define SBCH_LEN_ECHO    4'h1
`define SBCH_LEN_SUM     4'h2
`define SBCH_LEN_ERR     4'h9
`define SBCH_LEN_ID      4'hE
`define SBCH_LEN_STAT    4'h8
`define SBCH_ADDR_BYTES  3'h7

`define SBCH_FLASH_LO    16'h1000
`define SBCH_FLASH_HI    16'hFFFF
`define SBCH_SECT_FIRST  4'h1
`define SBCH_CHIP_AREA   8'h1F

`endif

//--- design/sbch_pkg.sv
// Types of the serial boot command handler
`default_nettype none
package sbch_pkg;

  typedef enum logic [4:0] {
    ST_MATCH, ST_BAUD, ST_BAUD_SWAP, ST_CMD, ST_ADDR, ST_PW, ST_AREA, ST_ERASE,
    ST_HEX, ST_SUM_GO, ST_SUM, ST_SEC_GO, ST_SEC, ST_EXEC, ST_RUN, ST_SEND, ST_HALT
  } sbch_state_t;

  typedef struct packed {
    sbch_state_t  st;
    sbch_state_t  after;
    logic [111:0] txbuf;
    logic [3:0]   left;
    logic         push;
    logic [7:0]   push_data;
    logic [7:0]   cmd;
    logic [2:0]   nbyte;
    logic         err;
    logic [31:0]  pw_cnt_addr;
    logic [31:0]  pw_cmp_addr;
    logic         pw_req;
    logic         pw_valid;
    logic [7:0]   pw_data;
    logic [7:0]   baud_sel;
    logic         baud_apply;
    logic         hex_valid;
    logic [7:0]   hex_data;
    logic         hex_to_ram;
    logic         erase_req;
    logic         erase_chip;
    logic [3:0]   erase_first;
    logic [3:0]   erase_last;
    logic         sum_req;
    logic         sec_set_req;
    logic         exec_req;
    logic         halted;
  } sbch_reg_t;

endpackage : sbch_pkg
`default_nettype wire

//--- design/sbch_fifo.sv
// Small synchronous FIFO between the command engine and the transmitter
`timescale 1ns/1ps
`default_nettype none
module sbch_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } sbch_fifo_st_t;

  sbch_fifo_st_t s, nxt_s;
  logic          do_wr;
  logic          do_rd;

  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb begin
    nxt_s = s;
    if (do_wr) begin
      nxt_s.mem[s.wp] = in_data;
      // Depth is a power of two, so the pointer wraps by overflow
      nxt_s.wp = AW'(s.wp + 1'b1);
    end
    if (do_rd) begin
      nxt_s.rp = AW'(s.rp + 1'b1);
    end
    nxt_s.cnt = (AW+1)'(s.cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= nxt_s;
    end
  end

  default clocking fcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  fifo_no_overflow_a: assert property (s.cnt <= (AW+1)'(DEPTH))
    else $error("FIFO accepts data while full");
  fifo_count_a: assert property (do_wr && !do_rd |=> s.cnt == $past(s.cnt) + 1'b1)
    else $error("FIFO count did not follow a write");

endmodule : sbch_fifo
`default_nettype wire

//--- design/sbch_handler.sv
// Serial boot command handler: byte sequencer for the boot-mode link
`timescale 1ns/1ps
`default_nettype none
`include "sbch_map.svh"

// Functional notes
// - RAM loader forwards hex bytes to RAM; checksum only after a clean end.
// - After the loader checksum is sent, request a jump to the loaded program.
// - Loader command is refused while security is on.
// - Loader runs only after password match, check skipped for a blank part.
// - Checksum command sums flash 1000H to FFFFH and returns it.
// - No command exists to read flash contents back.
// - Identification sends a 13-byte code including the program memory extent.
// - Status sends a 7-byte code with FFE0H-FFFFH state and security state.
// - Security blocks flash write and loader commands on the serial link.
// - Security is cleared only by a whole-array chip erase.
// - Matching byte 5AH is echoed; any other byte gets no answer.
// - Valid baud code is echoed; else A1H, A3H, 62H triples, then halt.
// - From the fifth byte the modified baud rate applies.
// - Valid command echoed; else A1H, A3H, 63H triples, then halt.
// - Password mismatch halts silently until pin reset.
// - Reception error in addresses or password halts until reset.
// - Erase area byte: upper nibble start, lower nibble end.
// - After erase send checksum upper then lower byte; on error nothing.
// - Checksum returned only without reception or hex format error.
// - After any checksum but the loader's, wait for the next command at the new rate.
// - Chip or 4-kbyte sector erase; sector erase refused while secure.
// - Part counts as blank when FFE0H-FFFFH all hold FFH.
// - Commands 30H, 60H, 90H, C0H, C3H, FAH and F0H are recognised.
module sbch_handler #(
  parameter logic [71:0] ID_CODE   = 72'h0,  // Arbitrary product code
  parameter logic [47:0] STAT_CODE = 48'h0,  // Arbitrary fixed status prefix
  parameter int          FIFO_DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_err,
  input  wire logic        baud_code_ok,
  input  wire logic        blank_part,
  input  wire logic        secure,
  input  wire logic        pw_done,
  input  wire logic        pw_ok,
  input  wire logic        hex_end,
  input  wire logic        hex_fmt_err,
  input  wire logic        erase_done,
  input  wire logic        sum_done,
  input  wire logic [15:0] sum_value,
  input  wire logic        sec_set_done,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic [7:0]       baud_sel,
  output logic             baud_apply,
  output logic             pw_req,
  output logic [31:0]      pw_cnt_addr,
  output logic [31:0]      pw_cmp_addr,
  output logic             pw_valid,
  output logic [7:0]       pw_data,
  output logic             hex_valid,
  output logic [7:0]       hex_data,
  output logic             hex_to_ram,
  output logic             erase_req,
  output logic             erase_chip,
  output logic [3:0]       erase_first,
  output logic [3:0]       erase_last,
  output logic             sum_req,
  output logic             sec_set_req,
  output logic             exec_req,
  output logic             halted
);

  sbch_pkg::sbch_reg_t s, nxt_s;
  logic                fifo_in_ready;
  logic                fifo_out_valid;

  function automatic logic known_cmd(logic [7:0] c);
    // No read-back code exists: anything outside this set is an error
    known_cmd = (c == `SBCH_CMD_ERASE) || (c == `SBCH_CMD_WRITE) || (c == `SBCH_CMD_LOAD) ||
                (c == `SBCH_CMD_SUM)   || (c == `SBCH_CMD_ID)    || (c == `SBCH_CMD_STAT) ||
                (c == `SBCH_CMD_SECURE);
  endfunction : known_cmd

  function automatic sbch_pkg::sbch_reg_t load_tx(sbch_pkg::sbch_reg_t r, logic [111:0] d,
                                                   logic [3:0] n, sbch_pkg::sbch_state_t nx);
    load_tx       = r;
    load_tx.txbuf = d;
    load_tx.left  = n;
    load_tx.after = nx;
    load_tx.st    = sbch_pkg::ST_SEND;
  endfunction : load_tx

  function automatic logic [111:0] err_triple(logic [7:0] code);
    err_triple = {{3{`SBCH_ERR_HDR1}}, {3{`SBCH_ERR_HDR2}}, {3{code}}, 40'h0};
  endfunction : err_triple

  always_comb begin
    nxt_s             = s;
    nxt_s.pw_req      = 1'b0;
    nxt_s.pw_valid    = 1'b0;
    nxt_s.hex_valid   = 1'b0;
    nxt_s.baud_apply  = 1'b0;
    nxt_s.erase_req   = 1'b0;
    nxt_s.sum_req     = 1'b0;
    nxt_s.sec_set_req = 1'b0;
    nxt_s.exec_req    = 1'b0;
    if (!(s.push && !fifo_in_ready)) begin
      nxt_s.push = 1'b0;
    end
    unique case (s.st)
      sbch_pkg::ST_MATCH: begin
        // Unrecognised bytes are dropped; the controller keeps retrying
        if (rx_valid && !rx_err && rx_data == `SBCH_MATCH_BYTE) begin
          nxt_s = load_tx(nxt_s, {`SBCH_MATCH_BYTE, 104'h0}, `SBCH_LEN_ECHO, sbch_pkg::ST_BAUD);
        end
      end
      sbch_pkg::ST_BAUD: begin
        if (rx_valid) begin
          if (rx_err || !baud_code_ok) begin
            nxt_s = load_tx(nxt_s, err_triple(`SBCH_ERR_BAUD), `SBCH_LEN_ERR, sbch_pkg::ST_HALT);
          end else begin
            nxt_s.cmd = rx_data;
            nxt_s = load_tx(nxt_s, {rx_data, 104'h0}, `SBCH_LEN_ECHO, sbch_pkg::ST_BAUD_SWAP);
          end
        end
      end
      sbch_pkg::ST_BAUD_SWAP: begin
        // Switch only once the echo has left, so it still goes out at the old rate
        if (!fifo_out_valid && !s.push) begin
          nxt_s.baud_sel   = s.cmd;
          nxt_s.baud_apply = 1'b1;
          nxt_s.st         = sbch_pkg::ST_CMD;
        end
      end
      sbch_pkg::ST_CMD: begin
        if (rx_valid && !rx_err) begin
          nxt_s.cmd   = rx_data;
          nxt_s.nbyte = 3'h0;
          nxt_s.err   = 1'b0;
          if (!known_cmd(rx_data)) begin
            nxt_s = load_tx(nxt_s, err_triple(`SBCH_ERR_CMD), `SBCH_LEN_ERR, sbch_pkg::ST_HALT);
          end else if (secure && (rx_data == `SBCH_CMD_WRITE || rx_data == `SBCH_CMD_LOAD)) begin
            nxt_s.st = sbch_pkg::ST_HALT;
          end else if (rx_data == `SBCH_CMD_ID) begin
            nxt_s = load_tx(nxt_s, {rx_data, ID_CODE, `SBCH_FLASH_LO, `SBCH_FLASH_HI},
                            `SBCH_LEN_ID, sbch_pkg::ST_CMD);
          end else if (rx_data == `SBCH_CMD_STAT) begin
            nxt_s = load_tx(nxt_s, {rx_data, STAT_CODE, 6'h00, secure, blank_part, 48'h0},
                            `SBCH_LEN_STAT, sbch_pkg::ST_CMD);
          end else if (rx_data == `SBCH_CMD_SUM) begin
            nxt_s.hex_to_ram = 1'b0;
            nxt_s = load_tx(nxt_s, {rx_data, 104'h0}, `SBCH_LEN_ECHO, sbch_pkg::ST_SUM_GO);
          end else if (rx_data == `SBCH_CMD_SECURE) begin
            nxt_s = load_tx(nxt_s, {rx_data, 104'h0}, `SBCH_LEN_ECHO, sbch_pkg::ST_SEC_GO);
          end else begin
            nxt_s.hex_to_ram = (rx_data == `SBCH_CMD_LOAD);
            nxt_s = load_tx(nxt_s, {rx_data, 104'h0}, `SBCH_LEN_ECHO, sbch_pkg::ST_ADDR);
          end
        end
      end
      sbch_pkg::ST_ADDR: begin
        if (rx_valid) begin
          if (rx_err) begin
            nxt_s.st = sbch_pkg::ST_HALT;
          end else begin
            // Count address bytes first, then compare address, upper part first
            if (s.nbyte[2]) begin
              nxt_s.pw_cmp_addr = {s.pw_cmp_addr[23:0], rx_data};
            end else begin
              nxt_s.pw_cnt_addr = {s.pw_cnt_addr[23:0], rx_data};
            end
            nxt_s.nbyte = 3'(s.nbyte + 1'b1);
            if (s.nbyte == `SBCH_ADDR_BYTES) begin
              if (blank_part) begin
                // Blank part: no password string follows
                nxt_s.st = (s.cmd == `SBCH_CMD_ERASE) ? sbch_pkg::ST_AREA : sbch_pkg::ST_HEX;
              end else begin
                nxt_s.pw_req = 1'b1;
                nxt_s.st     = sbch_pkg::ST_PW;
              end
            end
          end
        end
      end
      sbch_pkg::ST_PW: begin
        if (rx_valid && rx_err) begin
          nxt_s.st = sbch_pkg::ST_HALT;
        end else if (pw_done) begin
          if (!pw_ok) begin
            nxt_s.st = sbch_pkg::ST_HALT;
          end else begin
            nxt_s.st = (s.cmd == `SBCH_CMD_ERASE) ? sbch_pkg::ST_AREA : sbch_pkg::ST_HEX;
          end
        end else if (rx_valid) begin
          nxt_s.pw_valid = 1'b1;
          nxt_s.pw_data  = rx_data;
        end
      end
      sbch_pkg::ST_AREA: begin
        if (rx_valid) begin
          nxt_s.erase_first = rx_data[7:4];
          nxt_s.erase_last  = rx_data[3:0];
          nxt_s.erase_chip  = (rx_data == `SBCH_CHIP_AREA);
          // A bad or refused range answers nothing and falls back to waiting
          if (rx_err || rx_data[7:4] < `SBCH_SECT_FIRST || rx_data[7:4] > rx_data[3:0] ||
              (secure && rx_data != `SBCH_CHIP_AREA)) begin
            nxt_s.st = sbch_pkg::ST_CMD;
          end else begin
            nxt_s.erase_req = 1'b1;
            nxt_s.st        = sbch_pkg::ST_ERASE;
          end
        end
      end
      sbch_pkg::ST_ERASE: begin
        if (erase_done) begin
          nxt_s.st = sbch_pkg::ST_SUM_GO;
        end
      end
      sbch_pkg::ST_HEX: begin
        if (rx_valid && !rx_err) begin
          nxt_s.hex_valid = 1'b1;
          nxt_s.hex_data  = rx_data;
        end
        if ((rx_valid && rx_err) || hex_fmt_err) begin
          nxt_s.err = 1'b1;
        end
        if (hex_end) begin
          // Any error seen during the transfer suppresses the checksum reply
          nxt_s.st = (s.err || hex_fmt_err || (rx_valid && rx_err)) ? sbch_pkg::ST_CMD
                                                                     : sbch_pkg::ST_SUM_GO;
        end
      end
      sbch_pkg::ST_SUM_GO: begin
        nxt_s.sum_req = 1'b1;
        nxt_s.st      = sbch_pkg::ST_SUM;
      end
      sbch_pkg::ST_SUM: begin
        if (sum_done) begin
          nxt_s = load_tx(nxt_s, {sum_value, 96'h0}, `SBCH_LEN_SUM,
                          (s.cmd == `SBCH_CMD_LOAD) ? sbch_pkg::ST_EXEC : sbch_pkg::ST_CMD);
        end
      end
      sbch_pkg::ST_SEC_GO: begin
        nxt_s.sec_set_req = 1'b1;
        nxt_s.st          = sbch_pkg::ST_SEC;
      end
      sbch_pkg::ST_SEC: begin
        if (sec_set_done) begin
          nxt_s.st = sbch_pkg::ST_CMD;
        end
      end
      sbch_pkg::ST_EXEC: begin
        nxt_s.exec_req = 1'b1;
        nxt_s.st       = sbch_pkg::ST_RUN;
      end
      sbch_pkg::ST_RUN: begin
        nxt_s.st = sbch_pkg::ST_RUN;
      end
      sbch_pkg::ST_SEND: begin
        // Bytes leave whole; the serialiser adds start and stop bits
        if (!(s.push && !fifo_in_ready)) begin
          if (s.left != 4'h0) begin
            nxt_s.push      = 1'b1;
            nxt_s.push_data = s.txbuf[111:104];
            nxt_s.txbuf     = {s.txbuf[103:0], 8'h00};
            nxt_s.left      = 4'(s.left - 1'b1);
          end else begin
            nxt_s.st = s.after;
          end
        end
      end
      sbch_pkg::ST_HALT: begin
        nxt_s.halted = 1'b1;
      end
      default: begin
        nxt_s.st = sbch_pkg::ST_HALT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s    <= '0;
      s.st <= sbch_pkg::ST_MATCH;
    end else begin
      s <= nxt_s;
    end
  end

  sbch_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (s.push),
    .in_data   (s.push_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  assign tx_valid    = fifo_out_valid;
  assign baud_sel    = s.baud_sel;
  assign baud_apply  = s.baud_apply;
  assign pw_req      = s.pw_req;
  assign pw_cnt_addr = s.pw_cnt_addr;
  assign pw_cmp_addr = s.pw_cmp_addr;
  assign pw_valid    = s.pw_valid;
  assign pw_data     = s.pw_data;
  assign hex_valid   = s.hex_valid;
  assign hex_data    = s.hex_data;
  assign hex_to_ram  = s.hex_to_ram;
  assign erase_req   = s.erase_req;
  assign erase_chip  = s.erase_chip;
  assign erase_first = s.erase_first;
  assign erase_last  = s.erase_last;
  assign sum_req     = s.sum_req;
  assign sec_set_req = s.sec_set_req;
  assign exec_req    = s.exec_req;
  assign halted      = s.halted;

  default clocking hcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  match_echo_a: assert property (
    s.st == sbch_pkg::ST_MATCH && rx_valid && !rx_err && rx_data == `SBCH_MATCH_BYTE
    |-> ##2 (s.push && s.push_data == `SBCH_MATCH_BYTE))
    else $error("Matching byte not echoed");
  match_silent_a: assert property (
    s.st == sbch_pkg::ST_MATCH && rx_valid && rx_data != `SBCH_MATCH_BYTE
    |=> s.st == sbch_pkg::ST_MATCH && !s.push)
    else $error("Answer sent for a non-matching byte");
  baud_error_a: assert property (
    s.st == sbch_pkg::ST_BAUD && rx_valid && !baud_code_ok
    |-> ##2 (s.push && s.push_data == `SBCH_ERR_HDR1))
    else $error("Baud error triple did not start");
  cmd_error_a: assert property (
    s.st == sbch_pkg::ST_CMD && rx_valid && !rx_err && !known_cmd(rx_data)
    |=> s.st == sbch_pkg::ST_SEND && s.after == sbch_pkg::ST_HALT && s.left == `SBCH_LEN_ERR)
    else $error("Unknown command not answered by error triple");
  halt_sticky_a: assert property (
    s.st == sbch_pkg::ST_HALT |=> s.st == sbch_pkg::ST_HALT && !s.push ##1 s.halted)
    else $error("Halt state left or transmitting");
  pw_mismatch_a: assert property (
    s.st == sbch_pkg::ST_PW && pw_done && !pw_ok && !(rx_valid && rx_err) |=> s.st == sbch_pkg::ST_HALT)
    else $error("Password mismatch did not halt");
  pw_rx_error_a: assert property (
    (s.st == sbch_pkg::ST_ADDR || s.st == sbch_pkg::ST_PW) && rx_valid && rx_err
    |=> s.st == sbch_pkg::ST_HALT)
    else $error("Reception error in password phase did not halt");
  secure_block_a: assert property (
    s.st == sbch_pkg::ST_CMD && rx_valid && !rx_err && secure &&
    (rx_data == `SBCH_CMD_WRITE || rx_data == `SBCH_CMD_LOAD)
    |=> s.st == sbch_pkg::ST_HALT ##1 !s.push)
    else $error("Secured part accepted write or loader");
  sector_secure_a: assert property (
    s.st == sbch_pkg::ST_AREA && rx_valid && secure && rx_data != `SBCH_CHIP_AREA
    |=> !s.erase_req && s.st == sbch_pkg::ST_CMD)
    else $error("Sector erase started while secured");
  sum_upper_a: assert property (
    s.st == sbch_pkg::ST_SUM && sum_done |-> ##2 (s.push && s.push_data == $past(sum_value[15:8], 2)))
    else $error("Checksum upper byte not sent first");
  exec_jump_a: assert property (
    s.st == sbch_pkg::ST_EXEC |=> s.exec_req ##1 !s.exec_req)
    else $error("Jump request not a single pulse");

  erase_path_c: cover property (s.st == sbch_pkg::ST_ERASE && erase_done);
  loader_run_c: cover property (s.exec_req);
  halt_seen_c:  cover property (s.st == sbch_pkg::ST_SEND && s.after == sbch_pkg::ST_HALT);
  id_sent_c:    cover property (s.st == sbch_pkg::ST_CMD && rx_valid && rx_data == `SBCH_CMD_ID);

endmodule : sbch_handler
`default_nettype wire

//--- bench/sbch_far_model.sv
// Far side stand-in: erase, checksum, password and security engines plus serialiser
`timescale 1ns/1ps
`default_nettype none
module sbch_far_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire logic [3:0]  lag,
  input  wire logic [15:0] sum_in,
  input  wire logic        erase_req,
  input  wire logic        sum_req,
  input  wire logic        sec_set_req,
  input  wire logic        pw_req,
  output logic             erase_done,
  output logic             sum_done,
  output logic [15:0]      sum_value,
  output logic             sec_set_done,
  output logic             pw_done,
  output logic             tx_ready
);
  logic [3:0] job;
  logic [3:0] wait_cnt;
  // Serialiser busy half the time at random, so the answer path sees stalls
  assign tx_ready = !stall;
  // Outside its pulse the value is inverted, a stale value must never pass
  assign sum_value = sum_done ? sum_in : ~sum_in;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      job <= 4'h0;
      wait_cnt <= 4'h0;
      {erase_done, sum_done, sec_set_done, pw_done} <= 4'h0;
    end else begin
      {erase_done, sum_done, sec_set_done, pw_done} <= 4'h0;
      if (erase_req || sum_req || sec_set_req || pw_req) begin
        job <= {erase_req, sum_req, sec_set_req, pw_req};
        wait_cnt <= lag;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
        if (wait_cnt == 4'h1) {erase_done, sum_done, sec_set_done, pw_done} <= job;
      end
    end
  end
endmodule : sbch_far_model
`default_nettype wire

//--- bench/test_serial_boot_command_handler.sv
// Self-checking bench of the serial boot command handler
`timescale 1ns/1ps
`default_nettype none
`include "sbch_map.svh"
module test_serial_boot_command_handler;
  typedef logic [7:0] sbch_byteq_t[$];
  localparam logic [71:0] ID_CODE   = 72'h11_2233_4455_6677_8899;  // Arbitrary value
  localparam logic [47:0] STAT_CODE = 48'hA0B1_C2D3_E4F5;          // Arbitrary value
  logic clk, sys_rst, rx_valid, rx_err, baud_code_ok, blank_part, secure, pw_ok, hex_end, hex_fmt_err;
  logic stall, erase_done, sum_done, sec_set_done, pw_done, tx_ready, tx_valid, baud_apply, pw_req;
  logic pw_valid, hex_valid, hex_to_ram, erase_req, erase_chip, sum_req, sec_set_req, exec_req, halted;
  logic [7:0]  rx_data, tx_data, baud_sel, pw_data, hex_data;
  logic [3:0]  lag, erase_first, erase_last;
  logic [15:0] sum_in, sum_value;
  logic [31:0] pw_cnt_addr, pw_cmp_addr, seed;
  logic [63:0] addr;
  sbch_byteq_t seen, exp;
  int          n_mismatch, cmp_count, n_apply, n_erase, cycles, i;
  sbch_handler #(.ID_CODE(ID_CODE), .STAT_CODE(STAT_CODE), .FIFO_DEPTH(4)) i_sbch_handler (.*);
  sbch_far_model i_sbch_far_model (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic sbch_byteq_t err_bytes(input logic [7:0] code);
    return '{8'hA1, 8'hA1, 8'hA1, 8'hA3, 8'hA3, 8'hA3, code, code, code};
  endfunction : err_bytes
  always @(posedge clk) begin
    if (tx_valid && tx_ready) seen.push_back(tx_data);
    if (baud_apply) n_apply++;
    if (erase_req && erase_chip && erase_first == 4'h1 && erase_last == 4'hF) n_erase++;
    cycles++;
    if (cycles > 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  always @(negedge clk) stall <= 1'(rnd() & 32'h1);
  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : check
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask : send
  task automatic expect_bytes(input string what);
    int t;
    for (t = 0; t < 600 && seen.size() < exp.size(); t++) @(negedge clk);
    // Short settle so that a surplus byte is also caught
    repeat (30) @(negedge clk);
    check(16'(seen.size()), 16'(exp.size()), what);
    foreach (exp[k]) if (k < seen.size()) check({8'h00, seen[k]}, {8'h00, exp[k]}, what);
    seen = {};
  endtask : expect_bytes
  task automatic start_link(input logic good);
    int t;
    int a0;
    sys_rst = 1'b1;
    // Rate switches are counted across resets, so only this link's own one is checked
    a0 = n_apply;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    send(8'h5A ^ 8'(rnd() | 32'h1));
    exp = {};
    expect_bytes("stray byte");
    send(`SBCH_MATCH_BYTE);
    exp = '{`SBCH_MATCH_BYTE};
    expect_bytes("match echo");
    baud_code_ok = good;
    send(8'h28);
    baud_code_ok = 1'b0;
    exp = good ? '{8'h28} : err_bytes(`SBCH_ERR_BAUD);
    expect_bytes("baud answer");
    for (t = 0; t < 100 && good && n_apply == a0; t++) @(negedge clk);
    check(16'(n_apply - a0), 16'(good), "rate switch");
  endtask : start_link
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    {rx_valid, rx_err, baud_code_ok, secure, hex_end, hex_fmt_err, sys_rst} = 7'h01;
    {blank_part, pw_ok, rx_data, lag, sum_in, seed} = {2'h3, 8'h00, 4'h3, 16'h0000, 32'h0000_05C5};
    start_link(1'b0);
    check(16'(halted), 16'h0001, "halt after baud error");
    send(`SBCH_MATCH_BYTE);
    exp = {};
    expect_bytes("input while halted");
    $display("test bad baud done");
    start_link(1'b1);
    send(`SBCH_CMD_ERASE);
    exp = '{`SBCH_CMD_ERASE};
    expect_bytes("erase echo");
    for (i = 0; i < 8; i++) begin
      addr = {addr[55:0], 8'(rnd())};
      send(addr[7:0]);
    end
    check(16'(pw_cnt_addr !== addr[63:32]), 16'h0000, "count address");
    check(16'(pw_cmp_addr !== addr[31:0]), 16'h0000, "compare address");
    sum_in = 16'(rnd());
    lag = 4'h9;
    send(`SBCH_CHIP_AREA);
    exp = '{sum_in[15:8], sum_in[7:0]};
    expect_bytes("erase checksum");
    check(16'(n_erase), 16'h0001, "chip erase request");
    send(`SBCH_CMD_STAT);
    exp = '{`SBCH_CMD_STAT};
    for (i = 5; i >= 0; i--) exp.push_back(STAT_CODE[8*i +: 8]);
    exp.push_back({6'h00, secure, blank_part});
    expect_bytes("status code");
    send(`SBCH_CMD_ID);
    exp = '{`SBCH_CMD_ID};
    for (i = 8; i >= 0; i--) exp.push_back(ID_CODE[8*i +: 8]);
    exp = {exp, 8'h10, 8'h00, 8'hFF, 8'hFF};
    expect_bytes("product code");
    sum_in = 16'(rnd());
    send(`SBCH_CMD_SUM);
    exp = '{`SBCH_CMD_SUM, sum_in[15:8], sum_in[7:0]};
    expect_bytes("flash checksum");
    $display("test erase, status and id done");
    start_link(1'b1);
    do rx_data = 8'(rnd());
    while (rx_data inside {8'h30, 8'h60, 8'h90, 8'hC0, 8'hC3, 8'hFA, 8'hF0});
    send(rx_data);
    exp = err_bytes(`SBCH_ERR_CMD);
    expect_bytes("unknown command");
    check(16'(halted), 16'h0001, "halt after command error");
    $display("test unknown command done");
    secure = 1'b1;
    start_link(1'b1);
    send(`SBCH_CMD_LOAD);
    exp = {};
    expect_bytes("loader while secure");
    check(16'(halted), 16'h0001, "halt on secure loader");
    $display("test secure loader done");
    {secure, blank_part, pw_ok} = 3'h0;
    start_link(1'b1);
    send(`SBCH_CMD_ERASE);
    // Eight address bytes, then one password byte before the engine answers
    for (i = 0; i < 9; i++) send(8'(rnd()));
    exp = '{`SBCH_CMD_ERASE};
    expect_bytes("password mismatch");
    check(16'(halted), 16'h0001, "halt on password mismatch");
    $display("test password mismatch done");
    tally_and_finish();
  end
endmodule : test_serial_boot_command_handler
`default_nettype wire
